// file: core/rrc_reset_remap.sv
// What this block does
// - after any reset, flash decodes at address zero
// - remap bit set puts SRAM at zero
// - clearing remap bit returns flash to zero
// - every reset clears the remap bit
// - boot pin high: configure, then branch to zero
// - factory configuration code hidden from user code
// - four reset sources, status bits accumulate until cleared, not just the last one
// - external reset while running zeroes all status bits; a watchdog or software-reset set in the same cycle still wins
// - writing one to clear bit clears status
// - partial status clear causes a reset event
// - software-reset bit forces reset, stays set
// - watchdog expiry sets watchdog status bit
// - power-on reset sets power-on status bit
// - config bit two keeps DAC through watchdog and software resets
// - config bit zero keeps GPIO through watchdog and software resets
// - config write framed by two key writes
//
// Local design decision: the AXI4-Lite register port.
module rrc_reset_remap (
    // clock and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins and watchdog
    input wire logic ext_reset_pin_n,
    input wire logic boot_mode_pin_n,
    input wire logic wdt_expired,
    // axi4-lite write address
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // resets and memory map
    output rrc_pkg::rrc_reset_out_type reset_out,
    output rrc_pkg::rrc_map_out_type map_out
);

    localparam int CNT_W = 16;

    if (rrc_pkg::RESET_HOLD_CYCLES >= (1 << CNT_W) || rrc_pkg::KERNEL_RUN_CYCLES >= (1 << CNT_W)
            || rrc_pkg::RESET_HOLD_CYCLES < 1 || rrc_pkg::KERNEL_RUN_CYCLES < 1) begin : g_bad
        $error("rrc_reset_remap: timing counts do not fit the counter");
    end

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_KERNEL,
        ST_USER,
        ST_LOADER
    } rrc_state_type;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_LOADED
    } rrc_key_type;

    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(rrc_pkg::RESET_HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] KERNEL_LAST = CNT_W'(rrc_pkg::KERNEL_RUN_CYCLES - 1);

    logic ext_n_level;
    logic boot_n_level;
    rrc_state_type state;
    rrc_state_type next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    rrc_pkg::rrc_cause_type cause;
    rrc_pkg::rrc_cause_type next_cause;
    logic [rrc_pkg::STATUS_W-1:0] status;
    logic [rrc_pkg::STATUS_W-1:0] next_status;
    logic [7:0] remap;
    logic [7:0] cfg;
    logic [7:0] cfg_pending;
    rrc_key_type key_state;
    rrc_key_type next_key_state;
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane0_q;

    // pin synchronisers
    rrc_sync3 #(
        .WIDTH(2),
        .RESET_VALUE(2'h3)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_async({ext_reset_pin_n, boot_mode_pin_n}),
        .out_level({ext_n_level, boot_n_level})
    );

    // write decode: both channels held and response slot free
    wire wr_fire = aw_held && w_held && !bvalid;
    wire wr_lane = wr_fire && w_lane0_q;
    wire [7:0] wr_byte = w_data_q[7:0];
    wire wr_remap = wr_lane && (aw_addr_q == rrc_pkg::REMAP_ADDR);
    wire wr_status = wr_lane && (aw_addr_q == rrc_pkg::STATUS_ADDR);
    wire wr_clear = wr_lane && (aw_addr_q == rrc_pkg::CLEAR_ADDR);
    wire wr_key1 = wr_lane && (aw_addr_q == rrc_pkg::KEY1_ADDR);
    wire wr_cfg = wr_lane && (aw_addr_q == rrc_pkg::CFG_ADDR);
    wire wr_key2 = wr_lane && (aw_addr_q == rrc_pkg::KEY2_ADDR);
    wire wr_mapped = (aw_addr_q == rrc_pkg::REMAP_ADDR) || (aw_addr_q == rrc_pkg::STATUS_ADDR)
        || (aw_addr_q == rrc_pkg::CLEAR_ADDR) || (aw_addr_q == rrc_pkg::KEY1_ADDR)
        || (aw_addr_q == rrc_pkg::CFG_ADDR) || (aw_addr_q == rrc_pkg::KEY2_ADDR);

    // reset triggers
    wire running = (state != ST_HOLD);
    wire trig_ext = !ext_n_level && running;
    wire trig_wdt = wdt_expired && running;
    wire trig_sw = wr_status && wr_byte[rrc_pkg::SWR_BIT];
    wire [rrc_pkg::STATUS_W-1:0] clr_bits = wr_byte[rrc_pkg::STATUS_W-1:0];
    wire trig_part = wr_clear && ((status & ~clr_bits) != '0);
    wire any_trig = trig_ext || trig_wdt || trig_sw || trig_part;
    wire keep_cause = (cause == rrc_pkg::CAUSE_WATCHDOG) || (cause == rrc_pkg::CAUSE_SOFTWARE);

    // read decode
    wire [7:0] rd_byte = (araddr == rrc_pkg::REMAP_ADDR) ? remap
        : (araddr == rrc_pkg::STATUS_ADDR) ? {5'h00, status}
        : (araddr == rrc_pkg::CFG_ADDR) ? cfg
        : 8'h00;
    wire rd_mapped = (araddr == rrc_pkg::REMAP_ADDR) || (araddr == rrc_pkg::STATUS_ADDR)
        || (araddr == rrc_pkg::CLEAR_ADDR) || (araddr == rrc_pkg::KEY1_ADDR)
        || (araddr == rrc_pkg::CFG_ADDR) || (araddr == rrc_pkg::KEY2_ADDR);

    // sequencer: hold reset, run hidden configuration, then branch or stay in loader
    always_comb begin
        next_state = state;
        next_count = count;
        next_cause = cause;
        case (state)
            ST_HOLD: begin
                if (!ext_n_level) begin
                    next_count = '0;
                end else if (count == HOLD_LAST) begin
                    next_state = ST_KERNEL;
                    next_count = '0;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            ST_KERNEL: begin
                if (count == KERNEL_LAST) begin
                    next_state = boot_n_level ? ST_USER : ST_LOADER;
                    next_count = '0;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            ST_USER: begin
                next_count = '0;
            end
            ST_LOADER: begin
                next_count = '0;
            end
            default: begin
                next_state = ST_HOLD;
                next_count = '0;
            end
        endcase
        if (any_trig) begin
            next_state = ST_HOLD;
            next_count = '0;
            if (trig_ext) begin
                next_cause = rrc_pkg::CAUSE_EXTERNAL;
            end else if (trig_wdt) begin
                next_cause = rrc_pkg::CAUSE_WATCHDOG;
            end else begin
                next_cause = rrc_pkg::CAUSE_SOFTWARE;
            end
        end
    end

    // status: clear first, then external zeroing, then hardware sets win
    always_comb begin
        next_status = status;
        if (wr_clear) begin
            next_status = next_status & ~clr_bits;
        end
        if (trig_ext) begin
            next_status = '0;
        end
        if (wdt_expired) begin
            next_status[rrc_pkg::WDT_BIT] = 1'b1;
        end
        if (trig_sw) begin
            next_status[rrc_pkg::SWR_BIT] = 1'b1;
        end
    end

    // key sequence: key one, configuration value, key two, nothing between
    always_comb begin
        next_key_state = key_state;
        if (wr_key1 && wr_byte == rrc_pkg::KEY_FIRST) begin
            next_key_state = KEY_ARMED;
        end else if (wr_cfg && key_state == KEY_ARMED) begin
            next_key_state = KEY_LOADED;
        end else if (wr_fire) begin
            next_key_state = KEY_IDLE;
        end
    end

    // sequencer, cause and status registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_HOLD;
            count <= '0;
            cause <= rrc_pkg::CAUSE_POWER;
            status <= rrc_pkg::STATUS_POR_RESET;
        end else begin
            state <= next_state;
            count <= next_count;
            cause <= next_cause;
            status <= next_status;
        end
    end

    // remap and keyed configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remap <= rrc_pkg::REMAP_RESET;
            cfg <= rrc_pkg::CFG_RESET;
            cfg_pending <= rrc_pkg::CFG_RESET;
            key_state <= KEY_IDLE;
        end else begin
            key_state <= next_key_state;
            if (!running || any_trig) begin
                remap <= rrc_pkg::REMAP_RESET;
            end else if (wr_remap) begin
                remap <= {7'h00, wr_byte[rrc_pkg::REMAP_BIT]};
            end
            if (wr_cfg && key_state == KEY_ARMED) begin
                cfg_pending <= wr_byte & rrc_pkg::CFG_WRITABLE;
            end
            if (wr_key2 && wr_byte == rrc_pkg::KEY_SECOND && key_state == KEY_LOADED) begin
                cfg <= cfg_pending;
            end
        end
    end

    // reset lines and map outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_out <= '0;
            map_out <= '0;
        end else begin
            reset_out.system_n <= running;
            reset_out.gpio_n <= running || (keep_cause && cfg[rrc_pkg::GPIO_KEEP_BIT]);
            reset_out.dac_n <= running || (keep_cause && cfg[rrc_pkg::DAC_KEEP_BIT]);
            map_out.sram_at_zero <= remap[rrc_pkg::REMAP_BIT];
            map_out.kernel_visible <= (state == ST_KERNEL);
            map_out.user_start <= (state == ST_KERNEL) && (next_state == ST_USER);
            map_out.loader_mode <= (state == ST_LOADER);
        end
    end

    // write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= rrc_pkg::RESP_OKAY;
        end else begin
            awready <= !aw_held && !(awvalid && awready);
            wready <= !w_held && !(wvalid && wready);
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_lane0_q <= wstrb[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_mapped ? rrc_pkg::RESP_OKAY : rrc_pkg::RESP_DECERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel: one read under way, data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= rrc_pkg::RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= {24'h000000, rd_byte};
                rresp <= rd_mapped ? rrc_pkg::RESP_OKAY : rrc_pkg::RESP_DECERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end else begin
                arready <= !rvalid;
            end
        end
    end

    // checks
    sequence s_kernel_done;
        state == ST_KERNEL && next_state == ST_USER;
    endsequence

    sequence s_user_branch;
        ##1 (state == ST_USER && map_out.user_start) ##1 !map_out.kernel_visible;
    endsequence

    property p_flash_after_reset;
        @(posedge aclk) disable iff (!aresetn)
        (state == ST_HOLD) |=> ##1 !map_out.sram_at_zero;
    endproperty
    a_flash_after_reset: assert property (p_flash_after_reset) else $error("remap not cleared");

    property p_remap_follows;
        @(posedge aclk) disable iff (!aresetn)
        (wr_remap && running && !any_trig) |=> ##1 (map_out.sram_at_zero == $past(wr_byte[0], 2));
    endproperty
    a_remap_follows: assert property (p_remap_follows) else $error("remap decode wrong");

    property p_boot_branch;
        @(posedge aclk) disable iff (!aresetn)
        s_kernel_done |-> s_user_branch;
    endproperty
    a_boot_branch: assert property (p_boot_branch) else $error("branch to user missing");

    property p_external_zero;
        @(posedge aclk) disable iff (!aresetn)
        (trig_ext && !wdt_expired) |=> (status == '0) && (state == ST_HOLD);
    endproperty
    a_external_zero: assert property (p_external_zero) else $error("external left flags");

    property p_watchdog_flag;
        @(posedge aclk) disable iff (!aresetn)
        wdt_expired |=> status[rrc_pkg::WDT_BIT] && (state == ST_HOLD || !$past(running));
    endproperty
    a_watchdog_flag: assert property (p_watchdog_flag) else $error("watchdog flag missing");

    property p_power_flag;
        @(posedge aclk)
        $rose(aresetn) |-> status[rrc_pkg::POR_BIT] && (state == ST_HOLD);
    endproperty
    a_power_flag: assert property (p_power_flag) else $error("power-on flag missing");

    property p_clear_bit;
        @(posedge aclk) disable iff (!aresetn)
        (wr_clear && clr_bits[rrc_pkg::POR_BIT]) |=> !status[rrc_pkg::POR_BIT];
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("clear did not clear");

    property p_partial_clear;
        @(posedge aclk) disable iff (!aresetn)
        trig_part |=> (state == ST_HOLD) ##1 !reset_out.system_n;
    endproperty
    a_partial_clear: assert property (p_partial_clear) else $error("partial clear no reset");

    property p_software_reset;
        @(posedge aclk) disable iff (!aresetn)
        trig_sw |=> status[rrc_pkg::SWR_BIT] && (state == ST_HOLD);
    endproperty
    a_software_reset: assert property (p_software_reset) else $error("software reset lost");

    property p_cfg_keyed;
        @(posedge aclk) disable iff (!aresetn)
        (cfg != $past(cfg)) |-> $past(wr_key2 && wr_byte == rrc_pkg::KEY_SECOND
            && key_state == KEY_LOADED);
    endproperty
    a_cfg_keyed: assert property (p_cfg_keyed) else $error("config changed unkeyed");

    property p_gpio_kept;
        @(posedge aclk) disable iff (!aresetn)
        (!running && keep_cause && cfg[rrc_pkg::GPIO_KEEP_BIT]) |=> reset_out.gpio_n;
    endproperty
    a_gpio_kept: assert property (p_gpio_kept) else $error("gpio reset not held off");

endmodule

// file: core/rrc_pkg.sv
package rrc_pkg;

    // core clock rate
    localparam int unsigned CLK_MHZ = 125;

    // register byte addresses
    localparam logic [31:0] REMAP_ADDR = 32'hffff0220;
    localparam logic [31:0] STATUS_ADDR = 32'hffff0230;
    localparam logic [31:0] CLEAR_ADDR = 32'hffff0234;
    localparam logic [31:0] KEY1_ADDR = 32'hffff0248;
    localparam logic [31:0] CFG_ADDR = 32'hffff024c;
    localparam logic [31:0] KEY2_ADDR = 32'hffff0250;

    // field positions
    localparam int REMAP_BIT = 0;
    localparam int POR_BIT = 0;
    localparam int WDT_BIT = 1;
    localparam int SWR_BIT = 2;
    localparam int GPIO_KEEP_BIT = 0;
    localparam int DAC_KEEP_BIT = 2;
    localparam int STATUS_W = 3;

    // reset values, masks and key codes
    localparam logic [7:0] REMAP_RESET = 8'h00;
    localparam logic [2:0] STATUS_POR_RESET = 3'h1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITABLE = 8'h05;
    localparam logic [7:0] KEY_FIRST = 8'h76;
    localparam logic [7:0] KEY_SECOND = 8'hb1;

    // timing: reset hold and hidden configuration run, rounded up
    localparam int unsigned RESET_HOLD_NS = 1000;
    localparam int unsigned KERNEL_RUN_NS = 2000;
    localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned KERNEL_RUN_CYCLES = (KERNEL_RUN_NS * CLK_MHZ + 999) / 1000;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CAUSE_POWER,
        CAUSE_EXTERNAL,
        CAUSE_WATCHDOG,
        CAUSE_SOFTWARE
    } rrc_cause_type;

    // reset lines handed to the rest of the chip
    typedef struct packed {
        logic system_n;
        logic gpio_n;
        logic dac_n;
    } rrc_reset_out_type;

    // memory map and boot indications
    typedef struct packed {
        logic sram_at_zero;
        logic kernel_visible;
        logic user_start;
        logic loader_mode;
    } rrc_map_out_type;

endpackage

// file: core/rrc_sync3.sv
module rrc_sync3 #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] in_async,
    output logic [WIDTH-1:0] out_level
);

    if (WIDTH < 1) begin : g_bad_width
        $error("rrc_sync3: WIDTH must be at least 1");
    end

    // three stages per bit; a change counts once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                s1 <= RESET_VALUE[i];
                s2 <= RESET_VALUE[i];
                s3 <= RESET_VALUE[i];
                out_level[i] <= RESET_VALUE[i];
            end else begin
                s1 <= in_async[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    out_level[i] <= s3;
                end
            end
        end
    end

endmodule

// file: verif/rrc_reset_remap_bench.sv
module rrc_reset_remap_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // one expected read answer
    typedef struct {
        string name;
        logic [31:0] data;
        logic [1:0] resp;
    } rrc_note_type;

    logic aclk, aresetn, ext_reset_pin_n, boot_mode_pin_n, wdt_expired;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    rrc_pkg::rrc_reset_out_type reset_out;
    rrc_pkg::rrc_map_out_type map_out;
    rrc_note_type rq[$];
    logic [1:0] bq[$];
    int err_total, n_tests;
    logic [7:0] v;

    rrc_reset_remap u_dut (
        .aclk, .aresetn, .ext_reset_pin_n, .boot_mode_pin_n, .wdt_expired,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .reset_out, .map_out
    );

    // core clock, 8 ns
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // monitor: oldest note against each answer
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            if (rq.size() == 0) begin
                check("spare read", 32'h0, 32'h1);
            end else begin
                check(rq[0].name, rq[0].data, rdata);
                check({rq[0].name, " resp"}, {30'h0, rq[0].resp}, {30'h0, rresp});
                void'(rq.pop_front());
            end
        end
        if (bvalid && bready) begin
            if (bq.size() == 0) begin
                check("spare write", 32'h0, 32'h1);
            end else begin
                check("write resp", {30'h0, bq.pop_front()}, {30'h0, bresp});
            end
        end
    end

    // write: address and data together, each released when taken
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        bq.push_back(er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (awvalid || wvalid);
        do @(posedge aclk); while (!bvalid);
    endtask

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        rq.push_back('{nm, e, er});
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
    endtask

    // keyed configuration write
    task automatic key_cfg(input logic [7:0] c);
        wr(rrc_pkg::KEY1_ADDR, rrc_pkg::KEY_FIRST, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::CFG_ADDR, c, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::KEY2_ADDR, rrc_pkg::KEY_SECOND, rrc_pkg::RESP_OKAY);
    endtask

    task automatic wait_user();
        int i;
        for (i = 0; i < 1000 && map_out.user_start !== 1'h1; i++) @(posedge aclk);
        check("user start", 32'h1, {31'h0, map_out.user_start});
        @(posedge aclk);
        check("boot map", 32'h0, {28'h0, map_out});
    endtask

    task automatic wait_hold();
        int i;
        for (i = 0; i < 20 && reset_out.system_n !== 1'h0; i++) @(posedge aclk);
        check("system held", 32'h0, {31'h0, reset_out.system_n});
        @(posedge aclk);
    endtask

    // watchdog expiry; keep = expected {dac_n, gpio_n} during hold
    task automatic dog(input logic [1:0] keep);
        wdt_expired <= 1'h1;
        @(posedge aclk);
        wdt_expired <= 1'h0;
        wait_hold();
        check("kept lines", {30'h0, keep}, {30'h0, reset_out.dac_n, reset_out.gpio_n});
        wait_user();
    endtask

    // bound on the whole run
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        aresetn = 1'h0;
        ext_reset_pin_n = 1'h1;
        boot_mode_pin_n = 1'h1;
        wdt_expired = 1'h0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        {awvalid, wvalid, arvalid} = '0;
        bready = 1'h1;
        rready = 1'h1;
        err_total = 0;
        n_tests = 0;
        v = 8'($urandom(39));
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        wait_user();
        rd("remap", rrc_pkg::REMAP_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        rd("status", rrc_pkg::STATUS_ADDR, 32'h1, rrc_pkg::RESP_OKAY);
        rd("config", rrc_pkg::CFG_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        rd("key read", rrc_pkg::KEY1_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        rd("unmapped", 32'hffff0240, 32'h0, rrc_pkg::RESP_DECERR);
        $display("reset values done");
        wr(rrc_pkg::REMAP_ADDR, 8'h01, rrc_pkg::RESP_OKAY);
        rd("remap set", rrc_pkg::REMAP_ADDR, 32'h1, rrc_pkg::RESP_OKAY);
        check("sram at zero", 32'h1, {31'h0, map_out.sram_at_zero});
        wr(rrc_pkg::REMAP_ADDR, 8'h00, rrc_pkg::RESP_OKAY);
        @(posedge aclk);
        check("flash at zero", 32'h0, {31'h0, map_out.sram_at_zero});
        wr(rrc_pkg::REMAP_ADDR, 8'h01, rrc_pkg::RESP_OKAY);
        dog(2'h0);
        rd("remap after", rrc_pkg::REMAP_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        rd("status dog", rrc_pkg::STATUS_ADDR, 32'h3, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::CLEAR_ADDR, 8'h03, rrc_pkg::RESP_OKAY);
        rd("status clr", rrc_pkg::STATUS_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        $display("remap and watchdog done");
        wr(rrc_pkg::STATUS_ADDR, 8'h04, rrc_pkg::RESP_OKAY);
        wait_hold();
        wait_user();
        rd("status sw", rrc_pkg::STATUS_ADDR, 32'h4, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::CLEAR_ADDR, 8'h04, rrc_pkg::RESP_OKAY);
        rd("status clr2", rrc_pkg::STATUS_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        $display("software reset done");
        wr(rrc_pkg::CFG_ADDR, 8'h05, rrc_pkg::RESP_OKAY);
        rd("cfg unkeyed", rrc_pkg::CFG_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        v = v & rrc_pkg::CFG_WRITABLE;
        key_cfg(v);
        rd("cfg keyed", rrc_pkg::CFG_ADDR, {24'h0, v}, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::KEY1_ADDR, rrc_pkg::KEY_FIRST, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::CFG_ADDR, ~v & 8'h05, rrc_pkg::RESP_OKAY);
        wr(rrc_pkg::KEY2_ADDR, 8'hb0, rrc_pkg::RESP_OKAY);
        rd("cfg bad key", rrc_pkg::CFG_ADDR, {24'h0, v}, rrc_pkg::RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            key_cfg({5'h0, k[1], 1'h0, k[0]});
            dog(k[1:0]);
        end
        $display("retention done");
        wr(rrc_pkg::STATUS_ADDR, 8'h04, rrc_pkg::RESP_OKAY);
        wait_hold();
        wait_user();
        wr(rrc_pkg::CLEAR_ADDR, 8'h02, rrc_pkg::RESP_OKAY);
        wait_hold();
        wait_user();
        $display("partial clear done");
        wr(rrc_pkg::REMAP_ADDR, 8'h01, rrc_pkg::RESP_OKAY);
        ext_reset_pin_n <= 1'h0;
        repeat (10) @(posedge aclk);
        ext_reset_pin_n <= 1'h1;
        wait_user();
        rd("status ext", rrc_pkg::STATUS_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        rd("remap ext", rrc_pkg::REMAP_ADDR, 32'h0, rrc_pkg::RESP_OKAY);
        $display("external reset done");
        boot_mode_pin_n <= 1'h0;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (500) @(posedge aclk);
        check("loader mode", 32'h1, {31'h0, map_out.loader_mode});
        rd("status por", rrc_pkg::STATUS_ADDR, 32'h1, rrc_pkg::RESP_OKAY);
        $display("loader boot done");
        complete_run();
    end
endmodule
